// ---- rtl/card_activation_sequencer.sv ----
// Purpose: Control state machine of a smart card interface.
// Assumes: All pins synchronous to core_clk_in; analog sensing arrives
//          as digital levels (supply discharged, supply settled, faults).
// Notes:   Open-drain pins are split into value and drive enable.
// How it works
// - Idle: card supply, reset, clock, lines low; host pins and flags float.
// - Insertion indicator is sense XOR polarity setting in idle and active.
// - Idle deactivation runs until supply near 1V; activation ignored before.
// - Alarm state looks like idle except the alarm flag is driven low.
// - Alarm leaves only to idle, when the host raises the power request.
// - Toggling the power request clears alarm; activation still waits discharge.
// - Active: supply at 3V or 5V by select; reset and clock follow host.
// - Active: alarm flag high; data lines usable only after ready goes low.
// - Fault timeout: over 5us goes to alarm, shorter returns to active.
// - Overtemperature disables the device and asserts the alarm flag.
// - Self-start: ready acts as card-present and supply-settled interrupt.
// - Self-start: stays powered while card present; removal deactivates.
// - Raising the power request runs the built-in deactivation sequence.
// - A fault lasting over 5us runs the built-in deactivation sequence without host help.
`timescale 1ns/100ps
`default_nettype none
module card_activation_sequencer (
    input  wire logic       core_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       power_request_n_in,
    input  wire logic       chip_select_n_in,
    input  wire logic       insertion_sense_in,
    input  wire logic       supply_level_select_in,
    input  wire logic       host_reset_in,
    input  wire logic       host_clock_in,
    input  wire logic       supply_discharged_in,
    input  wire logic       supply_settled_in,
    input  wire logic       supply_overload_in,
    input  wire logic       overtemp_in,
    input  wire logic [2:0] host_line_in,
    input  wire logic [2:0] card_line_in,
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    output logic            card_supply_en_out,
    output logic            card_supply_5v_out,
    output logic            card_rst_out,
    output logic            card_clk_out,
    output logic [2:0]      card_line_out,
    output logic [2:0]      card_line_oe_out,
    output logic [2:0]      host_line_out,
    output logic [2:0]      host_line_oe_out,
    output logic            insertion_indicator_n_out,
    output logic            ready_n_out,
    output logic            ready_oe_out,
    output logic            alarm_n_out,
    output logic            alarm_oe_out,
    output logic [7:0]      reg_rdata_out,
    output logic            irq_out
);
    card_seq_pkg::state_t state_reg, state_next;
    logic [6:0] fault_cnt_reg;
    logic [1:0] step_reg;
    logic [2:0] step_tmr_reg;
    logic [7:0] ctrl_reg;
    logic [card_seq_pkg::EV_BITS-1:0] status_reg, mask_reg, ev_set;
    logic       present_prev_reg;
    logic       polarity;
    logic       card_present;
    logic       fault;
    logic       discharged;
    logic       live;
    logic       lines_ok;

    assign polarity     = ctrl_reg[card_seq_pkg::CTRL_POL_BIT];
    // Indicator low means a card sits in the socket
    assign card_present = ~(insertion_sense_in ^ polarity);
    // Card removal counts as a fault so self-start mode shuts down
    assign fault        = supply_overload_in | ~card_present;
    // Activation waits for a finished sequence and a drained supply
    assign discharged   = (step_reg == card_seq_pkg::STEP_DONE) &&
                          supply_discharged_in;
    assign live         = (state_reg == card_seq_pkg::ST_ACTIVE) ||
                          (state_reg == card_seq_pkg::ST_FAULT);
    // Lines carry data only once ready has been pulled low
    assign lines_ok     = live && ready_oe_out && !chip_select_n_in;

    // Next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            card_seq_pkg::ST_IDLE: begin
                if (!power_request_n_in && discharged) begin
                    state_next = card_seq_pkg::ST_ACTIVE;
                end
            end
            card_seq_pkg::ST_ACTIVE: begin
                if (power_request_n_in) begin
                    state_next = card_seq_pkg::ST_IDLE;
                end else if (fault) begin
                    state_next = card_seq_pkg::ST_FAULT;
                end
            end
            card_seq_pkg::ST_FAULT: begin
                if (!fault) begin
                    state_next = card_seq_pkg::ST_ACTIVE;
                end else if (fault_cnt_reg == card_seq_pkg::FAULT_CYC) begin
                    state_next = card_seq_pkg::ST_ALARM;
                end
            end
            card_seq_pkg::ST_ALARM: begin
                if (power_request_n_in && !overtemp_in) begin
                    state_next = card_seq_pkg::ST_IDLE;
                end
            end
        endcase
        // Heat shuts everything down from any state
        if (overtemp_in) begin
            state_next = card_seq_pkg::ST_ALARM;
        end
    end

    // State register
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= card_seq_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Fault duration timer, counts only while in fault timeout
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault_cnt_reg <= 7'h00;
        end else if (state_reg == card_seq_pkg::ST_FAULT) begin
            fault_cnt_reg <= fault_cnt_reg + 7'h01;
        end else begin
            fault_cnt_reg <= 7'h00;
        end
    end

    // Built-in deactivation steps; restarts each time the card goes live
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            step_reg     <= card_seq_pkg::STEP_DONE;
            step_tmr_reg <= 3'h0;
        end else if (live) begin
            step_reg     <= card_seq_pkg::STEP_RST;
            step_tmr_reg <= 3'h0;
        end else if (step_reg != card_seq_pkg::STEP_DONE) begin
            if (step_tmr_reg == card_seq_pkg::DEACT_STEP_CYC - 3'h1) begin
                step_reg     <= step_reg + 2'h1;
                step_tmr_reg <= 3'h0;
            end else begin
                step_tmr_reg <= step_tmr_reg + 3'h1;
            end
        end
    end

    // Card supply, reset and clock; the sequence drops them in order
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            card_supply_en_out <= 1'b0;
            card_supply_5v_out <= 1'b0;
            card_rst_out       <= 1'b0;
            card_clk_out       <= 1'b0;
        end else if (live) begin
            card_supply_en_out <= 1'b1;
            card_supply_5v_out <= supply_level_select_in;
            card_rst_out       <= host_reset_in;
            card_clk_out       <= host_clock_in;
        end else begin
            card_supply_en_out <= card_supply_en_out &&
                                  (step_reg != card_seq_pkg::STEP_DONE);
            card_rst_out       <= 1'b0;
            card_clk_out       <= card_clk_out &&
                                  (step_reg == card_seq_pkg::STEP_RST);
        end
    end

    // Flags: ready as card-present interrupt, alarm per state
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ready_n_out  <= 1'b1;
            ready_oe_out <= 1'b0;
            alarm_n_out  <= 1'b1;
            alarm_oe_out <= 1'b0;
            insertion_indicator_n_out <= 1'b1;
        end else begin
            ready_n_out  <= 1'b0;
            ready_oe_out <= live && supply_settled_in;
            alarm_n_out  <= (state_reg != card_seq_pkg::ST_ALARM);
            alarm_oe_out <= (state_reg != card_seq_pkg::ST_IDLE);
            insertion_indicator_n_out <= insertion_sense_in ^ polarity;
        end
    end

    // Channel direction: the first side to pull low owns the channel
    genvar ch;
    generate
        for (ch = 0; ch < card_seq_pkg::CHANS; ch++) begin : chan_g
            card_seq_pkg::dir_t dir_reg;
            always_ff @(posedge core_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    dir_reg <= card_seq_pkg::DIR_NONE;
                end else if (!lines_ok) begin
                    dir_reg <= card_seq_pkg::DIR_NONE;
                end else if (dir_reg == card_seq_pkg::DIR_NONE) begin
                    if (!host_line_in[ch]) begin
                        dir_reg <= card_seq_pkg::DIR_HOST;
                    end else if (!card_line_in[ch]) begin
                        dir_reg <= card_seq_pkg::DIR_CARD;
                    end
                end else if (host_line_in[ch] && card_line_in[ch]) begin
                    dir_reg <= card_seq_pkg::DIR_NONE;
                end
            end
            // Idle drives card lines low and floats host lines
            always_ff @(posedge core_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    card_line_out[ch]    <= 1'b0;
                    card_line_oe_out[ch] <= 1'b1;
                    host_line_out[ch]    <= 1'b0;
                    host_line_oe_out[ch] <= 1'b0;
                end else begin
                    card_line_out[ch]    <= 1'b0;
                    host_line_out[ch]    <= 1'b0;
                    card_line_oe_out[ch] <= live ? (lines_ok &&
                        dir_reg == card_seq_pkg::DIR_HOST &&
                        !host_line_in[ch]) : 1'b1;
                    host_line_oe_out[ch] <= lines_ok &&
                        dir_reg == card_seq_pkg::DIR_CARD &&
                        !card_line_in[ch];
                end
            end
        end
    endgenerate

    // Events for the status register
    always_comb begin
        ev_set = '0;
        ev_set[card_seq_pkg::EV_ACTIVE] =
            state_reg == card_seq_pkg::ST_IDLE &&
            state_next == card_seq_pkg::ST_ACTIVE;
        ev_set[card_seq_pkg::EV_FAULT] =
            state_reg == card_seq_pkg::ST_ACTIVE &&
            state_next == card_seq_pkg::ST_FAULT;
        ev_set[card_seq_pkg::EV_ALARM] =
            state_reg != card_seq_pkg::ST_ALARM &&
            state_next == card_seq_pkg::ST_ALARM;
        ev_set[card_seq_pkg::EV_HOT]    = overtemp_in;
        ev_set[card_seq_pkg::EV_INSERT] = card_present && !present_prev_reg;
    end

    // Control, mask and sticky status; a new event beats a write-one clear
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_reg         <= card_seq_pkg::CTRL_RESET;
            mask_reg         <= card_seq_pkg::MASK_RESET[4:0];
            status_reg       <= '0;
            present_prev_reg <= 1'b0;
        end else begin
            present_prev_reg <= card_present;
            if (reg_write_in && reg_addr_in == card_seq_pkg::CTRL_ADDR) begin
                ctrl_reg <= reg_wdata_in;
            end
            if (reg_write_in && reg_addr_in == card_seq_pkg::MASK_ADDR) begin
                mask_reg <= reg_wdata_in[card_seq_pkg::EV_BITS-1:0];
            end
            if (reg_write_in && reg_addr_in == card_seq_pkg::STATUS_ADDR) begin
                status_reg <= (status_reg &
                    ~reg_wdata_in[card_seq_pkg::EV_BITS-1:0]) | ev_set;
            end else begin
                status_reg <= status_reg | ev_set;
            end
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= 8'h00;
            irq_out       <= 1'b0;
        end else begin
            irq_out       <= |(status_reg & mask_reg);
            reg_rdata_out <= 8'h00;
            if (reg_read_in) begin
                unique case (reg_addr_in)
                    card_seq_pkg::CTRL_ADDR:   reg_rdata_out <= ctrl_reg;
                    card_seq_pkg::STATUS_ADDR: reg_rdata_out <= {3'h0, status_reg};
                    card_seq_pkg::MASK_ADDR:   reg_rdata_out <= {3'h0, mask_reg};
                    card_seq_pkg::STATE_ADDR:  reg_rdata_out <=
                        {3'h0, discharged, step_reg, state_reg};
                    default:                   reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    idle_pins_float_a: assert property (
        state_reg == card_seq_pkg::ST_IDLE |=>
        !alarm_oe_out && !ready_oe_out && host_line_oe_out == 3'h0 &&
        card_line_oe_out == 3'h7 && !card_rst_out)
        else $error("idle pins not in rest state");
    indicator_xor_a: assert property (
        1'b1 |=> insertion_indicator_n_out ==
        $past(insertion_sense_in ^ polarity))
        else $error("insertion indicator wrong");
    early_activation_a: assert property (
        state_reg == card_seq_pkg::ST_IDLE && !discharged |=>
        state_reg != card_seq_pkg::ST_ACTIVE)
        else $error("activation before discharge");
    alarm_flag_low_a: assert property (
        state_reg == card_seq_pkg::ST_ALARM |=> alarm_oe_out && !alarm_n_out)
        else $error("alarm flag not driven low");
    alarm_exit_a: assert property (
        state_reg == card_seq_pkg::ST_ALARM && !power_request_n_in |=>
        state_reg == card_seq_pkg::ST_ALARM)
        else $error("alarm left without power release");
    reset_follow_a: assert property (
        state_reg == card_seq_pkg::ST_ACTIVE |=>
        card_rst_out == $past(host_reset_in) &&
        card_supply_5v_out == $past(supply_level_select_in))
        else $error("card reset or level not following");
    fault_limit_a: assert property (
        state_reg == card_seq_pkg::ST_ACTIVE && fault && !overtemp_in &&
        !power_request_n_in ##1 (fault && !overtemp_in)[*8] |->
        state_reg == card_seq_pkg::ST_FAULT)
        else $error("fault timeout left early");
    hot_shutdown_a: assert property (
        overtemp_in |=> state_reg == card_seq_pkg::ST_ALARM ##1
        (alarm_oe_out && !alarm_n_out))
        else $error("overtemperature not handled");
    release_deact_a: assert property (
        state_reg == card_seq_pkg::ST_ACTIVE && power_request_n_in &&
        !overtemp_in |=> state_reg == card_seq_pkg::ST_IDLE ##[1:20]
        !card_supply_en_out)
        else $error("deactivation sequence did not finish");
    fault_entry_a: assert property (
        state_reg == card_seq_pkg::ST_ACTIVE && fault &&
        !power_request_n_in && !overtemp_in |=>
        state_reg == card_seq_pkg::ST_FAULT)
        else $error("fault not timed");

    activate_c: cover property (
        state_reg == card_seq_pkg::ST_IDLE ##1
        state_reg == card_seq_pkg::ST_ACTIVE);
    fault_recover_c: cover property (
        state_reg == card_seq_pkg::ST_FAULT ##1
        state_reg == card_seq_pkg::ST_ACTIVE);
    alarm_clear_c: cover property (
        state_reg == card_seq_pkg::ST_ALARM ##1
        state_reg == card_seq_pkg::ST_IDLE);
endmodule
`default_nettype wire

// ---- rtl/card_seq_pkg.sv ----
// Purpose: Shared constants and types for the card activation sequencer.
// Assumes: 20 MHz core clock, 8-bit register port with 4-bit addresses.
// Notes:   Register offsets are byte addresses on the plain register port.
`default_nettype none
package card_seq_pkg;
    // Core clock period
    localparam int CLK_PERIOD_NS = 50;
    // Longest fault that still returns to the active state
    localparam int FAULT_LIMIT_NS = 5000;
    localparam int FAULT_CYC_I = FAULT_LIMIT_NS / CLK_PERIOD_NS;
    localparam logic [6:0] FAULT_CYC = 7'(FAULT_CYC_I);
    // Least spacing between steps of the built-in deactivation
    localparam int DEACT_STEP_NS = 200;
    localparam int DEACT_STEP_I =
        (DEACT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] DEACT_STEP_CYC = 3'(DEACT_STEP_I);
    // Deactivation steps: reset and lines low, clock low, hold, supply off
    localparam logic [1:0] STEP_RST  = 2'h0;
    localparam logic [1:0] STEP_CLK  = 2'h1;
    localparam logic [1:0] STEP_IO   = 2'h2;
    localparam logic [1:0] STEP_DONE = 2'h3;
    // Register offsets
    localparam logic [3:0] CTRL_ADDR   = 4'h0;
    localparam logic [3:0] STATUS_ADDR = 4'h4;
    localparam logic [3:0] MASK_ADDR   = 4'h8;
    localparam logic [3:0] STATE_ADDR  = 4'hc;
    // Control fields
    localparam int CTRL_POL_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    // Status event bits
    localparam int EV_ACTIVE  = 0;
    localparam int EV_FAULT   = 1;
    localparam int EV_ALARM   = 2;
    localparam int EV_HOT     = 3;
    localparam int EV_INSERT  = 4;
    localparam int EV_BITS    = 5;
    // Channel count: data, aux one, aux two
    localparam int CHANS = 3;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACTIVE = 2'b01,
        ST_FAULT  = 2'b10,
        ST_ALARM  = 2'b11
    } state_t;
    typedef enum logic [1:0] {
        DIR_NONE = 2'b00,
        DIR_HOST = 2'b01,
        DIR_CARD = 2'b10
    } dir_t;
endpackage
`default_nettype wire

// ---- test/card_supply_model.sv ----
// Purpose: Behavioural card supply seen by the sequencer's analog senses.
// Assumes: Supply ramps one step a cycle, or every other cycle when slow.
// Notes:   Discharge flag sits near a fifth of full scale, settled at top.
`timescale 1ns/100ps
`default_nettype none
module card_supply_model #(
    parameter int RAMP_CYC = 40
) (
    input  wire logic core_clk_in,
    input  wire logic reset_n_in,
    input  wire logic supply_en_in,
    input  wire logic slow_in,
    output logic      discharged_out,
    output logic      settled_out
);
    int   level;
    logic half;
    // Charge while enabled, bleed off otherwise; slow mimics a heavy load
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            level <= 0;
            half <= 1'b0;
        end else begin
            half <= ~half;
            if (!slow_in || half) begin
                if (supply_en_in && level < RAMP_CYC)
                    level <= level + 1;
                else if (!supply_en_in && level > 0)
                    level <= level - 1;
            end
        end
    end
    // Flags are levels, never pulses, so the sequencer can poll them
    assign discharged_out = level < RAMP_CYC / 5;
    assign settled_out    = level == RAMP_CYC;
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the card activation sequencer.
// Assumes: Bench is the host; lines are open drain with pull-ups.
// Notes:   Waits are bounded; a hang ends in the timeout counter.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clk = 0, rst_n = 0, power_request_n = 1, cs_n = 1, sense = 0;
    logic       sel5 = 1, h_rst = 0, h_clk = 0, ovl = 0, hot = 0;
    logic       we = 0, re = 0, slow = 0, self_st = 0;
    logic [2:0] hpull = 0, cpull = 0;
    logic [3:0] addr = 0;
    logic [7:0] wd = 0;
    logic       dis, stl, sup, s5, crst, cclk, ind, rdy_n, rdy_oe;
    logic       al_n, al_oe, irq;
    logic [2:0] clo, coe, hlo, hoe;
    logic [7:0] rdat;
    int         err_count = 0, comparisons = 0, cyc = 0, i, t0, t1, t2;
    // Rows: polarity, sense, expected indicator
    logic [2:0] rows [4] = '{3'b000, 3'b011, 3'b101, 3'b110};

    always #25 clk = ~clk;

    card_supply_model i_sup (.core_clk_in(clk), .reset_n_in(rst_n),
        .supply_en_in(sup), .slow_in(slow), .discharged_out(dis),
        .settled_out(stl));
    // Self-start wires the indicator back onto the power request
    card_activation_sequencer i_dut (.core_clk_in(clk), .reset_n_in(rst_n),
        .power_request_n_in(self_st ? ind : power_request_n), .chip_select_n_in(cs_n),
        .insertion_sense_in(sense), .supply_level_select_in(sel5),
        .host_reset_in(h_rst), .host_clock_in(h_clk),
        .supply_discharged_in(dis), .supply_settled_in(stl),
        .supply_overload_in(ovl), .overtemp_in(hot),
        .host_line_in(~hoe & ~hpull), .card_line_in(~coe & ~cpull),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_write_in(we),
        .reg_read_in(re), .card_supply_en_out(sup), .card_supply_5v_out(s5),
        .card_rst_out(crst), .card_clk_out(cclk), .card_line_out(clo),
        .card_line_oe_out(coe), .host_line_out(hlo), .host_line_oe_out(hoe),
        .insertion_indicator_n_out(ind), .ready_n_out(rdy_n),
        .ready_oe_out(rdy_oe), .alarm_n_out(al_n), .alarm_oe_out(al_oe),
        .reg_rdata_out(rdat), .irq_out(irq));

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Whole run needs under 2000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [7:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdchk(input string nm, input logic [3:0] a,
                         input logic [7:0] m, exp);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1 chk(nm, exp, rdat & m);
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return sup;
            1: return rdy_oe;
            2: return al_oe;
            default: return al_n;
        endcase
    endfunction

    task automatic await(input int s, input logic v, input int lim);
        string nm [4] = '{"supply_en", "ready_oe", "alarm_oe", "alarm_n"};
        // Step off the edge so freshly launched outputs have settled
        #1;
        for (int k = 0; k < lim && pick(s) !== v; k++) begin
            @(posedge clk);
            #1;
        end
        chk(nm[s], {7'h0, v}, {7'h0, pick(s)});
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk("idle_supply", 8'h00, {7'h0, sup});
        chk("idle_oe", 8'h38, {rdy_oe, al_oe, coe, hoe});
        rdchk("ctrl", card_seq_pkg::CTRL_ADDR, 8'hff, 8'h00);
        rdchk("mask", card_seq_pkg::MASK_ADDR, 8'hff, 8'h00);
        rdchk("unmapped", 4'h2, 8'hff, 8'h00);
        done("reset");
        for (i = 0; i < 4; i++) begin
            wr(card_seq_pkg::CTRL_ADDR, {7'h0, rows[i][2]});
            sense <= rows[i][1];
            repeat (3) @(posedge clk);
            #1 chk("indicator", {7'h0, rows[i][0]}, {7'h0, ind});
        end
        wr(card_seq_pkg::STATUS_ADDR, 8'h1f);
        wr(card_seq_pkg::MASK_ADDR, 8'h01);
        done("indicator");
        // Activation, reset and clock following, interrupt
        @(posedge clk) power_request_n <= 1'b0;
        await(0, 1, 10);
        chk("supply_5v", 8'h01, {7'h0, s5});
        await(1, 1, 100);
        chk("alarm_active", 8'h03, {6'h0, al_oe, al_n});
        @(posedge clk) h_rst <= 1'b1;
        h_clk <= 1'b1; // One clean step, then held steady
        repeat (2) @(posedge clk);
        #1 chk("rst_clk", 8'h03, {6'h0, crst, cclk});
        chk("irq_set", 8'h01, {7'h0, irq});
        rdchk("status", card_seq_pkg::STATUS_ADDR, 8'h1f, 8'h01);
        wr(card_seq_pkg::STATUS_ADDR, 8'h01);
        repeat (2) @(posedge clk);
        #1 chk("irq_clear", 8'h00, {7'h0, irq});
        @(posedge clk) cs_n <= 1'b0;
        hpull <= 3'b001;
        cpull <= 3'b100;
        repeat (4) @(posedge clk);
        #1 chk("line_fwd", 8'h0c, {2'h0, coe, hoe});
        chk("line_vals", 8'h00, {1'b0, rdy_n, clo, hlo});
        @(posedge clk) hpull <= 3'b000;
        cpull <= 3'b000;
        repeat (4) @(posedge clk);
        #1 chk("line_rel", 8'h00, {2'h0, coe, hoe});
        done("active");
        // Short fault returns, long fault goes to alarm
        @(posedge clk) ovl <= 1'b1;
        rdchk("state_fault", 4'hc, 8'h03, {6'h0, card_seq_pkg::ST_FAULT});
        repeat (48) @(posedge clk);
        ovl <= 1'b0;
        rdchk("state_back", 4'hc, 8'h03, {6'h0, card_seq_pkg::ST_ACTIVE});
        @(posedge clk) ovl <= 1'b1;
        repeat (95) @(posedge clk);
        #1 chk("alarm_wait", 8'h01, {7'h0, al_n});
        repeat (15) @(posedge clk);
        #1 chk("alarm_low", 8'h02, {6'h0, al_oe, al_n});
        await(0, 0, 40);
        chk("alarm_lines", 8'h78, {rdy_oe, al_oe, coe, hoe});
        rdchk("status_ev", card_seq_pkg::STATUS_ADDR, 8'h1f, 8'h06);
        chk("irq_masked", 8'h00, {7'h0, irq});
        wr(card_seq_pkg::MASK_ADDR, 8'h04);
        repeat (2) @(posedge clk);
        #1 chk("irq_unmask", 8'h01, {7'h0, irq});
        @(posedge clk) ovl <= 1'b0;
        power_request_n <= 1'b1;
        await(2, 0, 10);
        rdchk("state_idle", 4'hc, 8'h03, {6'h0, card_seq_pkg::ST_IDLE});
        done("fault");
        // Built-in deactivation order, then early request is held off
        @(posedge clk) power_request_n <= 1'b0;
        sel5 <= 1'b0;
        await(1, 1, 150);
        chk("supply_3v", 8'h00, {7'h0, s5});
        @(posedge clk) power_request_n <= 1'b1;
        t0 = 0;
        t1 = 0;
        t2 = 0;
        for (i = 1; i < 20; i++) begin
            @(posedge clk);
            #1;
            if (!crst && t0 == 0) t0 = i;
            if (!cclk && t1 == 0) t1 = i;
            if (!sup && t2 == 0) t2 = i;
        end
        chk("deact_order", 8'h03, {6'h0, t0 <= t1, t1 < t2});
        @(posedge clk) power_request_n <= 1'b0;
        repeat (5) @(posedge clk);
        #1 chk("held_off", 8'h00, {7'h0, sup});
        await(0, 1, 100);
        done("deactivation");
        // Overtemperature, then a quick toggle out of alarm
        @(posedge clk) hot <= 1'b1;
        await(3, 0, 10);
        await(0, 0, 40);
        @(posedge clk) hot <= 1'b0;
        power_request_n <= 1'b1;
        @(posedge clk) power_request_n <= 1'b0;
        await(2, 0, 10);
        chk("toggle_wait", 8'h00, {7'h0, sup});
        await(0, 1, 100);
        done("overtemp");
        // Self-start on a slow supply; removal deactivates
        @(posedge clk) self_st <= 1'b1;
        slow <= 1'b1;
        await(1, 1, 200);
        @(posedge clk) sense <= 1'b0;
        // Removal is timed as a fault first, so allow the full timeout
        await(0, 0, 150);
        await(1, 0, 10);
        done("self_start");
        give_verdict();
    end
endmodule
`default_nettype wire
